// ===== src/asfd_core.sv
// Flags, ninth bits, error enables and shared data buffer of the asynchronous serial block, with APB slave.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps

// Overview of operation
// - Nine-bit mode captures ninth bit with data
// - Eight-bit mode ninth bit copies bit 7
// - Transmit ninth bit loads with data buffer
// - Error requests gated by per-flag enables
// - Empty flag: set on transfer, status-then-write clears
// - First transmit enable sets empty; empty interrupt
// - Complete flag follows empty and engine idle
// - Full flag: set on load, status-then-read clears
// - Idle flag after quiet line, own interrupt unless receive DMA enabled
// - Idle needs a valid character first
// - Overrun keeps buffered data, drops new
// - Data read clears only flags seen set
// - Noise flag set, cleared by sequence
// - Zero stop bit sets framing flag
// - Parity mismatch sets parity flag
// - Break sets framing, full; nine-bit mode clears ninth
// - Break clears by sequence, rearms after ones
// - Reception flag follows start search
// - One address: read received, write transmit
// - Length control selects nine or eight bits
module asfd_core
(
  // Clock and reset.
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // APB slave.
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [asfd_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic                              pready,
  output logic [31:0]                       prdata,
  output logic                              pslverr,
  // Receive line and sampling engine.
  input  wire logic                         serial_in_pin,
  input  wire asfd_pkg::asfd_rx_evt_type    rx_evt,
  // Transmit engine.
  input  wire asfd_pkg::asfd_tx_stat_type   tx_stat,
  output asfd_pkg::asfd_tx_xfer_type        tx_xfer,
  // Control levels for the engines and interrupt requests.
  output logic                              tx_enable,
  output logic                              rx_enable,
  output logic                              nine_bit_mode,
  output logic                              err_irq,
  output logic                              tx_irq,
  output logic                              line_quiet_irq
);
  import asfd_pkg::*;

  // All reset-bearing state of the block.
  typedef struct packed {
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic [7:0]       st;         // Status primary flags.
    logic             break_seen;
    logic             rx_active;
    logic [3:0]       err_en;     // Overrun, noise, framing, parity enables.
    logic             dma_rx_en;
    logic [5:0]       ctrl;
    logic [7:0]       snap1;      // Flags observed at the last status primary read.
    logic             snap2;      // Break flag observed at the last status secondary read.
    logic             idle_armed;
    logic             brk_armed;
    logic             te_seen;
    logic             rx_en_d;
    logic             pin_s1;
    logic             pin_s2;
    asfd_tx_xfer_type xfer;
    logic             err_irq;
    logic             tx_irq;
    logic             quiet_irq;
  } asfd_state_type;

  // Data and ninth bits that reset leaves alone, kept apart so reset touches nothing of them.
  typedef struct packed {
    logic [7:0] rx_buf;
    logic [7:0] tx_buf;
    logic       rx_ninth;
    logic       tx_ninth;
  } asfd_keep_type;

  asfd_state_type state_reg;   // Registered state.
  asfd_state_type state_next;  // Next state.
  asfd_keep_type  keep_reg;    // Unreset data holders.
  asfd_keep_type  keep_next;   // Their next value.

  logic [7:0] idx;        // Register index of the current address.
  logic       aligned;    // Address is word aligned and its bits above bit 9 are zero.
  logic       access;     // Access phase completes this edge.
  logic       wr_acc;     // Completed write.
  logic       rd_acc;     // Completed read.
  logic       setup;      // Setup cycle of a transfer.

  // Address decode helpers.
  assign idx     = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
  assign setup   = psel && !penable;
  assign access  = psel && penable && state_reg.pready;
  assign wr_acc  = access && pwrite;
  assign rd_acc  = access && !pwrite;

  // Next-state logic: bus, flag clearing, receive and transmit events, in that order so hardware sets win.
  always_comb
  begin
    state_next = state_reg;
    keep_next  = keep_reg;
    // Two-stage synchroniser for the receive pin.
    state_next.pin_s1 = serial_in_pin;
    state_next.pin_s2 = state_reg.pin_s1;
    // Zero wait states: ready is raised for the cycle after setup.
    state_next.pready = setup;
    state_next.pslverr = 1'b0;
    if (setup)
    begin
      // Read data is captured at setup so the snapshot below matches it.
      state_next.prdata = 32'h0000_0000;
      if (!aligned)
      begin
        state_next.pslverr = 1'b1;
      end
      else if (idx == IDX_STATUS_PRIMARY)
      begin
        state_next.prdata[7:0] = state_reg.st;
      end
      else if (idx == IDX_ENABLES)
      begin
        state_next.prdata[7:0] = {keep_reg.rx_ninth, keep_reg.tx_ninth, state_reg.dma_rx_en, 1'b0,
                                  state_reg.err_en};
      end
      else if (idx == IDX_DATA_BUFFER)
      begin
        state_next.prdata[7:0] = keep_reg.rx_buf;
      end
      else if (idx == IDX_STATUS_SECONDARY)
      begin
        state_next.prdata[S2_BREAK]  = state_reg.break_seen;
        state_next.prdata[S2_ACTIVE] = state_reg.rx_active;
      end
      else if (idx == IDX_CONTROL)
      begin
        state_next.prdata[5:0] = state_reg.ctrl;
      end
      else
      begin
        // Unmapped word: error answer, data reads zero.
        state_next.pslverr = 1'b1;
      end
    end
    // Register writes and read side effects at the completing edge.
    if (wr_acc && aligned)
    begin
      if (idx == IDX_ENABLES)
      begin
        keep_next.tx_ninth    = pwdata[EN_TX_NINTH];
        state_next.dma_rx_en  = pwdata[EN_DMA_RX];
        state_next.err_en     = pwdata[3:0];
      end
      else if (idx == IDX_CONTROL)
      begin
        state_next.ctrl = pwdata[5:0];
      end
      else if (idx == IDX_DATA_BUFFER)
      begin
        keep_next.tx_buf = pwdata[7:0];
        // Empty clears only if it was seen set at the last status read.
        if (state_reg.snap1[ST_TX_EMPTY])
        begin
          state_next.st[ST_TX_EMPTY]    = 1'b0;
          state_next.snap1[ST_TX_EMPTY] = 1'b0;
        end
      end
    end
    if (rd_acc && aligned)
    begin
      if (idx == IDX_STATUS_PRIMARY)
      begin
        state_next.snap1 = state_reg.prdata[7:0];
      end
      else if (idx == IDX_STATUS_SECONDARY)
      begin
        state_next.snap2 = state_reg.prdata[S2_BREAK];
      end
      else if (idx == IDX_DATA_BUFFER)
      begin
        // Receive flags clear only where the snapshot saw them set.
        state_next.st[5:0]    = state_reg.st[5:0] & ~state_reg.snap1[5:0];
        state_next.snap1[5:0] = 6'h00;
        if (state_reg.snap1[ST_IDLE])
        begin
          state_next.idle_armed = 1'b0;
        end
        if (state_reg.snap2)
        begin
          state_next.break_seen = 1'b0;
          state_next.snap2      = 1'b0;
        end
      end
    end
    // Receiver enable rising disarms idle until a character arrives.
    state_next.rx_en_d = state_reg.ctrl[CT_RX_EN];
    if (state_reg.ctrl[CT_RX_EN] && !state_reg.rx_en_d)
    begin
      state_next.idle_armed = 1'b0;
    end
    // Break may rearm only after the line shows ones again.
    if (state_reg.pin_s2)
    begin
      state_next.brk_armed = 1'b1;
    end
    // Reception in progress follows the start-bit search.
    if (rx_evt.start_zero)
    begin
      state_next.rx_active = 1'b1;
    end
    else if (rx_evt.false_start || rx_evt.idle)
    begin
      state_next.rx_active = 1'b0;
    end
    // Quiet line sets idle only once armed by a received character.
    if (rx_evt.idle && state_reg.idle_armed)
    begin
      state_next.st[ST_IDLE] = 1'b1;
    end
    if (rx_evt.brk)
    begin
      // A break counts as a character with a zero stop bit.
      state_next.st[ST_FRAMING] = 1'b1;
      state_next.st[ST_RX_FULL] = 1'b1;
      state_next.idle_armed     = 1'b1;
      if (state_reg.brk_armed)
      begin
        state_next.break_seen = 1'b1;
        state_next.brk_armed  = 1'b0;
      end
      if (state_reg.ctrl[CT_NINE_BIT])
      begin
        keep_next.rx_ninth = 1'b0;
      end
    end
    else if (rx_evt.done)
    begin
      if (state_reg.st[ST_RX_FULL])
      begin
        // New shift data is dropped; the buffer keeps the older byte.
        state_next.st[ST_OVERRUN] = 1'b1;
      end
      else
      begin
        keep_next.rx_buf          = rx_evt.data[7:0];
        // Ninth bit comes from the line or mirrors bit 7.
        keep_next.rx_ninth        = state_reg.ctrl[CT_NINE_BIT] ? rx_evt.data[8] : rx_evt.data[7];
        state_next.st[ST_RX_FULL] = 1'b1;
        state_next.idle_armed     = 1'b1;
        state_next.st[ST_NOISE]   = state_next.st[ST_NOISE] | rx_evt.noise;
        state_next.st[ST_FRAMING] = state_next.st[ST_FRAMING] | rx_evt.framing;
        state_next.st[ST_PARITY]  = state_next.st[ST_PARITY] | rx_evt.parity;
      end
    end
    // First transmitter enable sets empty so the preamble goes out.
    if (state_reg.ctrl[CT_TX_EN] && !state_reg.te_seen)
    begin
      state_next.te_seen        = 1'b1;
      state_next.st[ST_TX_EMPTY] = 1'b1;
    end
    // Buffer hands its character over when the shifter can take it.
    state_next.xfer.load = 1'b0;
    if (!state_reg.st[ST_TX_EMPTY] && state_reg.ctrl[CT_TX_EN] && tx_stat.shift_ready && !state_reg.xfer.load)
    begin
      state_next.xfer.load       = 1'b1;
      state_next.xfer.data       = {state_reg.ctrl[CT_NINE_BIT] & keep_reg.tx_ninth, keep_reg.tx_buf};
      state_next.st[ST_TX_EMPTY] = 1'b1;
    end
    // Complete is set while nothing waits or shifts; the engine's start latency sits in its own timing.
    state_next.st[ST_TX_DONE] = state_next.st[ST_TX_EMPTY] && !tx_stat.sending;
    // Interrupt lines are computed from the next state so each output is a flop.
    state_next.err_irq = |(state_next.st[3:0] & state_next.err_en);
    state_next.tx_irq  = (state_next.st[ST_TX_EMPTY] & state_next.ctrl[CT_TX_EMPTY_IE])
                       | (state_next.st[ST_TX_DONE] & state_next.ctrl[CT_TX_DONE_IE]);
    state_next.quiet_irq = state_next.st[ST_IDLE] & state_next.ctrl[CT_QUIET_IE] & !state_next.dma_rx_en;
  end

  // State register with asynchronous reset to constants.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg            <= '0;
      state_reg.st         <= STATUS_RESET;
      state_reg.err_en     <= ERR_EN_RESET;
      state_reg.ctrl       <= CONTROL_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Data holders carry no reset, so their contents survive it.
  always_ff @(posedge pclk)
  begin
    keep_reg <= keep_next;
  end

  // Outputs straight from flops.
  assign pready         = state_reg.pready;
  assign prdata         = state_reg.prdata;
  assign pslverr        = state_reg.pslverr;
  assign tx_xfer        = state_reg.xfer;
  assign tx_enable      = state_reg.ctrl[CT_TX_EN];
  assign rx_enable      = state_reg.ctrl[CT_RX_EN];
  assign nine_bit_mode  = state_reg.ctrl[CT_NINE_BIT];
  assign err_irq        = state_reg.err_irq;
  assign tx_irq         = state_reg.tx_irq;
  assign line_quiet_irq = state_reg.quiet_irq;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_overrun_keeps_buf: assert property (
    rx_evt.done && !rx_evt.brk && state_reg.st[ST_RX_FULL]
    |=> state_reg.st[ST_OVERRUN] && keep_reg.rx_buf == $past(keep_reg.rx_buf))
    else $error("overrun did not keep buffered data");

  a_rx_full_load: assert property (
    rx_evt.done && !rx_evt.brk && !state_reg.st[ST_RX_FULL]
    |=> state_reg.st[ST_RX_FULL] && keep_reg.rx_buf == $past(rx_evt.data[7:0]))
    else $error("received byte not loaded");

  a_idle_needs_arm: assert property (
    $rose(state_reg.st[ST_IDLE]) |-> $past(state_reg.idle_armed))
    else $error("idle set without a prior character");

  a_eight_bit_copy: assert property (
    rx_evt.done && !rx_evt.brk && !state_reg.st[ST_RX_FULL] && !state_reg.ctrl[CT_NINE_BIT]
    |=> keep_reg.rx_ninth == keep_reg.rx_buf[7])
    else $error("eight-bit ninth bit is not bit 7");

  a_tx_ninth_load: assert property (
    $rose(state_reg.xfer.load) |-> state_reg.xfer.data[8] == (state_reg.ctrl[CT_NINE_BIT] & keep_reg.tx_ninth)
    && state_reg.st[ST_TX_EMPTY] && state_reg.xfer.data[7:0] == keep_reg.tx_buf)
    else $error("transfer content or empty flag wrong");

  a_err_irq_gate: assert property (
    state_reg.st[ST_OVERRUN] && !state_reg.err_en[ST_OVERRUN] && !state_reg.err_en[ST_PARITY]
    && !state_reg.err_en[ST_NOISE] && !state_reg.err_en[ST_FRAMING] |-> !err_irq)
    else $error("error request without enable");

  a_break_sets_all: assert property (
    rx_evt.brk && state_reg.brk_armed
    |=> state_reg.break_seen && state_reg.st[ST_FRAMING] && state_reg.st[ST_RX_FULL])
    else $error("break did not set its flags");

  // A data write in that cycle queues a character, so complete must follow the new empty level.
  a_tc_follows: assert property (
    state_reg.st[ST_TX_EMPTY] && !state_reg.xfer.load && !tx_stat.sending
    |=> state_reg.st[ST_TX_DONE] == state_reg.st[ST_TX_EMPTY])
    else $error("complete flag not set when idle");

  // Complete is clear in the cycle after any cycle in which the engine is sending.
  a_tc_busy_clear: assert property (
    tx_stat.sending |=> !state_reg.st[ST_TX_DONE])
    else $error("complete flag set while sending");

  a_clear_needs_snap: assert property (
    rd_acc && idx == IDX_DATA_BUFFER && !state_reg.snap1[ST_RX_FULL] && state_reg.st[ST_RX_FULL]
    |=> state_reg.st[ST_RX_FULL])
    else $error("receive flag cleared without status read");

  a_answer_next: assert property (
    setup |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");

  c_overrun: cover property (state_reg.st[ST_OVERRUN] && rd_acc && idx == IDX_DATA_BUFFER);
  c_break: cover property ($rose(state_reg.break_seen));
  c_tx_load: cover property ($rose(state_reg.xfer.load) ##[1:20] state_reg.st[ST_TX_DONE]);
  c_idle_irq: cover property ($rose(line_quiet_irq));

endmodule : asfd_core

// ===== inc/asfd_pkg.sv
// Package with register map, field layout, reset values and carrier types of the serial flag and data block.
package asfd_pkg;

  // Printed register offsets are indexes; the byte address is four times the index.
  localparam logic [7:0] IDX_STATUS_PRIMARY  = 8'h16;
  localparam logic [7:0] IDX_ENABLES         = 8'h17;
  localparam logic [7:0] IDX_DATA_BUFFER     = 8'h18;
  localparam logic [7:0] IDX_STATUS_SECONDARY = 8'h19;
  localparam logic [7:0] IDX_CONTROL         = 8'h1a;
  localparam int         ADDR_W              = 12;

  // Status primary bit positions.
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_TX_DONE  = 6;
  localparam int ST_RX_FULL  = 5;
  localparam int ST_IDLE     = 4;
  localparam int ST_OVERRUN  = 3;
  localparam int ST_NOISE    = 2;
  localparam int ST_FRAMING  = 1;
  localparam int ST_PARITY   = 0;

  // Status secondary bit positions.
  localparam int S2_BREAK  = 1;
  localparam int S2_ACTIVE = 0;

  // Ninth bit and error enable register bit positions.
  localparam int EN_RX_NINTH = 7;
  localparam int EN_TX_NINTH = 6;
  localparam int EN_DMA_RX   = 5;

  // Control register bit positions.
  localparam int CT_TX_EN      = 0;
  localparam int CT_RX_EN      = 1;
  localparam int CT_NINE_BIT   = 2;
  localparam int CT_TX_EMPTY_IE = 3;
  localparam int CT_TX_DONE_IE = 4;
  localparam int CT_QUIET_IE   = 5;

  // Reset values.
  localparam logic [7:0] STATUS_RESET  = 8'hc0;
  localparam logic [3:0] ERR_EN_RESET  = 4'h0;
  localparam logic [5:0] CONTROL_RESET = 6'h00;

  // Events reported by the receive sampling engine, one-cycle pulses except data.
  typedef struct packed {
    logic       done;
    logic [8:0] data;
    logic       noise;
    logic       framing;
    logic       parity;
    logic       brk;
    logic       start_zero;
    logic       false_start;
    logic       idle;
  } asfd_rx_evt_type;

  // Transmit engine status toward this block.
  typedef struct packed {
    logic shift_ready;
    logic sending;
  } asfd_tx_stat_type;

  // Transfer of one character into the transmit shift register.
  typedef struct packed {
    logic       load;
    logic [8:0] data;
  } asfd_tx_xfer_type;

endpackage : asfd_pkg

// ===== sim/asfd_line_model.sv
// Behavioural model of the remote serial node as seen through the sampling and transmit engines.
`timescale 1ns/1ps

module asfd_line_model
  import asfd_pkg::*;
#(
  parameter int SEND_CYC = 20  // Cycles one character keeps the shifter busy.
)
(
  // Clock and reset.
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // Block side.
  input  wire asfd_pkg::asfd_tx_xfer_type tx_xfer,
  output asfd_pkg::asfd_rx_evt_type       rx_evt,
  output asfd_pkg::asfd_tx_stat_type      tx_stat,
  output logic                            serial_in_pin
);
  int unsigned left;    // Busy cycles still to go.
  int unsigned loads;   // Characters taken so far.
  logic [8:0]  last_tx; // Last character taken.

  // The line rests high and no event is pending at time zero.
  initial
  begin
    rx_evt        = '0;
    serial_in_pin = 1'b1;
  end

  // One event for one cycle; the data field is scrambled afterwards so stale data never looks valid.
  // The line settles first and the event follows two cycles later. A real break holds the line low for a
  // whole character, so the synchronised pin must not still show the old high level after the break.
  task automatic pulse(input asfd_rx_evt_type e, input logic pin);
    @(posedge pclk);
    serial_in_pin <= pin;
    repeat (2) @(posedge pclk);
    rx_evt        <= e;
    @(posedge pclk);
    rx_evt        <= '{data: ~e.data, default: '0};
  endtask : pulse

  // The shifter refuses further characters while it sends, as a real one would.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      left  <= 0;
      loads <= 0;
    end
    else if (tx_xfer.load)
    begin
      left    <= SEND_CYC;
      last_tx <= tx_xfer.data;
      loads   <= loads + 1;
    end
    else if (left != 0)
      left <= left - 1;
  end

  // Busy status follows the remaining send time.
  always_comb tx_stat = '{shift_ready: (left == 0), sending: (left != 0)};
endmodule : asfd_line_model

// ===== sim/testbench.sv
// Self-checking testbench of the serial flag and data block.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; $display("Error at %0t: got %h expected %h", $time, g, e); end end

module testbench;
  import asfd_pkg::*;
  localparam logic [ADDR_W-1:0] A_ST = {2'b00, IDX_STATUS_PRIMARY, 2'b00};
  localparam logic [ADDR_W-1:0] A_EN = {2'b00, IDX_ENABLES, 2'b00};
  localparam logic [ADDR_W-1:0] A_DB = {2'b00, IDX_DATA_BUFFER, 2'b00};
  localparam logic [ADDR_W-1:0] A_S2 = {2'b00, IDX_STATUS_SECONDARY, 2'b00};
  localparam logic [ADDR_W-1:0] A_CT = {2'b00, IDX_CONTROL, 2'b00};
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, serial_in_pin;
  logic              tx_enable, rx_enable, nine_bit_mode, err_irq, tx_irq, line_quiet_irq, rerr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rdv;
  logic [7:0]        m;
  asfd_rx_evt_type   rx_evt;
  asfd_tx_stat_type  tx_stat;
  asfd_tx_xfer_type  tx_xfer;
  int                err_total, checks, cyc;

  asfd_core asfd_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .serial_in_pin(serial_in_pin), .rx_evt(rx_evt), .tx_stat(tx_stat), .tx_xfer(tx_xfer),
    .tx_enable(tx_enable), .rx_enable(rx_enable), .nine_bit_mode(nine_bit_mode), .err_irq(err_irq),
    .tx_irq(tx_irq), .line_quiet_irq(line_quiet_irq));
  asfd_line_model line_inst (.pclk(pclk), .presetn(presetn), .tx_xfer(tx_xfer), .rx_evt(rx_evt),
    .tx_stat(tx_stat), .serial_in_pin(serial_in_pin));

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rdv = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
      err_total++;
  endtask : apb

  // Reads a register and compares the masked byte.
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] msk, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(rdv[7:0] & msk, e)
  endtask : rchk

  // Hands one received character with its error levels to the block.
  task automatic chr(input logic [8:0] d, input logic [2:0] nfp);
    line_inst.pulse('{done: 1'b1, data: d, noise: nfp[2], framing: nfp[1], parity: nfp[0], default: '0}, 1'b1);
  endtask : chr

  // Status read followed by data read, the normal clearing sequence.
  task automatic clr();
    apb(1'b0, A_ST, 8'h00);
    apb(1'b0, A_DB, 8'h00);
  endtask : clr

  // Waits, bounded, for the shifter to take a character; a missing load counts as a mismatch.
  task automatic wait_load();
    int n;
    int k;
    n = line_inst.loads;
    k = 0;
    while (line_inst.loads == n && k < 50)
    begin
      @(posedge pclk);
      k++;
    end
    `CHK(k < 50, 1'b1)
  endtask : wait_load

  // Clock of 4 ns period.
  initial pclk = 1'b0;
  always #2 pclk = ~pclk;

  // A hang is cut short well after the expected run length.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and a refused address.
    rchk(A_ST, 8'hff, 8'hc0);
    rchk(A_S2, 8'h03, 8'h00);
    rchk(A_EN, 8'h2f, 8'h00);
    apb(1'b0, 12'h04c, 8'h00);
    `CHK(rerr, 1'b1)
    // Nine-bit reception; idle must wait for a first character.
    apb(1'b1, A_CT, 8'h07);
    line_inst.pulse('{idle: 1'b1, default: '0}, 1'b1);
    rchk(A_ST, 8'h10, 8'h00);
    chr(9'h1a5, 3'b000);
    rchk(A_ST, 8'h20, 8'h20);
    rchk(A_EN, 8'h80, 8'h80);
    rchk(A_DB, 8'hff, 8'ha5);
    rchk(A_ST, 8'h20, 8'h00);
    line_inst.pulse('{idle: 1'b1, default: '0}, 1'b1);
    rchk(A_ST, 8'h10, 8'h10);
    apb(1'b1, A_CT, 8'h27);
    repeat (3) @(posedge pclk);
    `CHK(line_quiet_irq, 1'b1)
    apb(1'b1, A_EN, 8'h20);
    repeat (3) @(posedge pclk);
    `CHK(line_quiet_irq, 1'b0)
    apb(1'b1, A_EN, 8'h00);
    clr();
    line_inst.pulse('{idle: 1'b1, default: '0}, 1'b1);
    rchk(A_ST, 8'h10, 8'h00);
    // Eight-bit mode copies bit 7 into the ninth position.
    apb(1'b1, A_CT, 8'h03);
    chr(9'h080, 3'b000);
    rchk(A_EN, 8'h80, 8'h80);
    clr();
    chr(9'h17f, 3'b000);
    rchk(A_EN, 8'h80, 8'h00);
    clr();
    // Overrun between the two reads of a clearing sequence.
    chr(9'h011, 3'b000);
    rchk(A_ST, 8'h28, 8'h20);
    chr(9'h022, 3'b000);
    apb(1'b1, A_EN, 8'h08);
    repeat (3) @(posedge pclk);
    `CHK(err_irq, 1'b1)
    rchk(A_DB, 8'hff, 8'h11);
    rchk(A_ST, 8'h28, 8'h08);
    apb(1'b0, A_DB, 8'h00);
    rchk(A_ST, 8'h08, 8'h00);
    repeat (3) @(posedge pclk);
    `CHK(err_irq, 1'b0)
    // Noise, framing and parity, each with its own enable.
    for (int k = 0; k < 3; k++)
    begin
      m = 8'h04 >> k;
      chr(9'h055, m[2:0]);
      rchk(A_ST, 8'h0f, m);
      apb(1'b1, A_EN, 8'h0f ^ m);
      repeat (3) @(posedge pclk);
      `CHK(err_irq, 1'b0)
      apb(1'b1, A_EN, m);
      repeat (3) @(posedge pclk);
      `CHK(err_irq, 1'b1)
      apb(1'b0, A_DB, 8'h00);
      rchk(A_ST, 8'h2f, 8'h00);
    end
    apb(1'b1, A_EN, 8'h00);
    // Break in nine-bit mode, its clearing and rearming.
    apb(1'b1, A_CT, 8'h07);
    chr(9'h1ff, 3'b000);
    clr();
    line_inst.pulse('{brk: 1'b1, default: '0}, 1'b0);
    rchk(A_ST, 8'h22, 8'h22);
    rchk(A_EN, 8'h80, 8'h00);
    rchk(A_S2, 8'h02, 8'h02);
    apb(1'b0, A_DB, 8'h00);
    rchk(A_S2, 8'h02, 8'h00);
    clr();
    line_inst.pulse('{brk: 1'b1, default: '0}, 1'b0);
    rchk(A_S2, 8'h02, 8'h00);
    clr();
    line_inst.pulse('{start_zero: 1'b1, default: '0}, 1'b1);
    rchk(A_S2, 8'h01, 8'h01);
    line_inst.pulse('{false_start: 1'b1, default: '0}, 1'b1);
    rchk(A_S2, 8'h01, 8'h00);
    line_inst.pulse('{start_zero: 1'b1, default: '0}, 1'b1);
    line_inst.pulse('{idle: 1'b1, default: '0}, 1'b1);
    rchk(A_S2, 8'h01, 8'h00);
    line_inst.pulse('{brk: 1'b1, default: '0}, 1'b0);
    rchk(A_S2, 8'h02, 8'h02);
    // Transmit path with the ninth bit, then in eight-bit mode.
    apb(1'b1, A_EN, 8'h40);
    rchk(A_ST, 8'h80, 8'h80);
    apb(1'b1, A_DB, 8'h3c);
    wait_load();
    `CHK(line_inst.last_tx, 9'h13c)
    rchk(A_ST, 8'hc0, 8'h80);
    repeat (25) @(posedge pclk);
    rchk(A_ST, 8'hc0, 8'hc0);
    apb(1'b1, A_CT, 8'h03);
    apb(1'b1, A_DB, 8'hc3);
    wait_load();
    `CHK(line_inst.last_tx, 9'h0c3)
    repeat (25) @(posedge pclk);
    apb(1'b1, A_CT, 8'h0b);
    repeat (3) @(posedge pclk);
    `CHK(tx_irq, 1'b1)
    apb(1'b1, A_CT, 8'h03);
    repeat (3) @(posedge pclk);
    `CHK(tx_irq, 1'b0)
    apb(1'b1, A_CT, 8'h13);
    repeat (3) @(posedge pclk);
    `CHK(tx_irq, 1'b1)
    // A second reset restores the flags but keeps the data holders and ninth bits.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK({tx_enable, rx_enable, nine_bit_mode, tx_irq}, 4'h0)
    presetn <= 1'b1;
    rchk(A_ST, 8'hff, 8'hc0);
    rchk(A_EN, 8'hef, 8'h40);
    rchk(A_DB, 8'hff, 8'hff);
    apb(1'b1, A_DB, 8'h5a);
    rchk(A_ST, 8'hc0, 8'h00);
    apb(1'b1, A_CT, 8'h01);
    rchk(A_ST, 8'h80, 8'h80);
    `CHK({tx_enable, rx_enable, nine_bit_mode}, 3'b100)
    wrap_up();
  end
endmodule : testbench
